// *** src/tpm_monitor.sv ***
// Overview of operation
// (RQ1) Config bit 2 selects die or external sense.
// (RQ2) Scaling: 1 C/bit die, 4 mV/bit sense.
// (RQ3) Temperature reading is read-only 16-bit word.
// (RQ4) Output and input voltage peaks tracked.
// (RQ5) Temperature peak follows the temperature reading.
// (RQ6) Output and input current sense peaks tracked.
// (RQ7) Clear-all or peak write restarts peak tracking.
// (RQ8) Peak writes accept 0-2 bytes, data ignored.
// (RQ9) Host clears temperature peak on source change.
// (RQ10) Telemetry starts at 0x8000 until first conversion.
// (RQ11) Larger signed conversion replaces stored peak.
`default_nettype none
module tpm_monitor
  import tpm_pkg::*;
(
  // Clock and reset.
  input  wire logic            sys_clk,
  input  wire logic            sys_rst,
  // Telemetry initialisation events.
  input  wire logic            run_cycle,
  input  wire logic            maker_soft_reset,
  // Configuration.
  input  wire logic [7:0]      maker_configuration,
  // Conversion results.
  input  wire tpm_pkg::tpm_word_t output_voltage_reading,
  input  wire logic            output_voltage_valid,
  input  wire tpm_pkg::tpm_word_t input_voltage_reading,
  input  wire logic            input_voltage_valid,
  input  wire tpm_pkg::tpm_word_t output_current_reading,
  input  wire logic            output_current_valid,
  input  wire tpm_pkg::tpm_word_t input_current_reading,
  input  wire logic            input_current_valid,
  input  wire tpm_pkg::tpm_word_t die_temp_reading,
  input  wire logic            die_temp_valid,
  input  wire tpm_pkg::tpm_word_t external_temp_sense_pin,
  input  wire logic            external_temp_valid,
  // Register access port.
  input  wire logic [7:0]      cmd_code,
  input  wire logic            cmd_rd,
  input  wire logic            cmd_wr,
  input  wire logic [1:0]      cmd_wr_bytes,
  output var  tpm_pkg::tpm_word_t rd_data_reg,
  output var  logic            rd_ack_reg,
  output var  logic            cmd_err_reg
);
  import tpm_pkg::*;

  logic        tlm_init;
  logic        temp_ext;
  logic        temp_new_valid;
  tpm_word_t   temp_new;
  tpm_word_t   temp_reg;
  tpm_word_t   temp_next;
  tpm_word_t   rd_data_next;
  logic        rd_ack_next;
  logic        cmd_err_next;
  logic        clear_all;
  logic        wr_ok;
  logic        is_peak;
  logic [7:0]  peak_sel;
  tpm_word_t   samp  [TPM_NPEAK];
  logic        svld  [TPM_NPEAK];
  tpm_word_t   peak_val [TPM_NPEAK];

  localparam int TEMP_SRC_BIT_IDX = TPM_TEMP_SRC_BIT;

  assign tlm_init  = run_cycle | maker_soft_reset;
  assign temp_ext  = maker_configuration[TEMP_SRC_BIT_IDX];

  // Source select; both raw words already carry their own scaling.
  always_comb begin
    temp_new       = temp_ext ? external_temp_sense_pin : die_temp_reading; // RQ1 RQ2
    temp_new_valid = temp_ext ? external_temp_valid : die_temp_valid; // RQ1
    temp_next      = temp_reg;
    if (tlm_init) begin
      temp_next = TPM_TLM_INIT; // RQ10
    end else if (temp_new_valid) begin
      temp_next = temp_new;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      temp_reg <= TPM_TLM_INIT; // RQ10
    end else begin
      temp_reg <= temp_next;
    end
  end

  always_comb begin
    samp[TPM_PK_VOUT] = output_voltage_reading; // RQ4
    svld[TPM_PK_VOUT] = output_voltage_valid;
    samp[TPM_PK_VIN]  = input_voltage_reading; // RQ4
    svld[TPM_PK_VIN]  = input_voltage_valid;
    samp[TPM_PK_TEMP] = temp_new; // RQ5
    svld[TPM_PK_TEMP] = temp_new_valid & ~tlm_init;
    samp[TPM_PK_IOUT] = output_current_reading; // RQ6
    svld[TPM_PK_IOUT] = output_current_valid;
    samp[TPM_PK_IIN]  = input_current_reading; // RQ6
    svld[TPM_PK_IIN]  = input_current_valid;
  end

  assign peak_sel  = cmd_code - TPM_CMD_PEAK0;
  assign is_peak   = (cmd_code >= TPM_CMD_PEAK0) && (peak_sel < 8'(TPM_NPEAK));
  assign wr_ok     = cmd_wr && (cmd_wr_bytes <= TPM_WR_MAX_BYTES); // RQ8
  assign clear_all = wr_ok && (cmd_code == TPM_CMD_CLEAR); // RQ7

  genvar g;
  generate
    for (g = 0; g < TPM_NPEAK; g++) begin : g_pk
      tpm_peak_if pif ();
      assign pif.sample  = samp[g];
      assign pif.valid   = svld[g] & ~tlm_init;
      assign pif.clear   = tlm_init | clear_all | (wr_ok && is_peak && (peak_sel == 8'(g))); // RQ7 RQ10
      assign peak_val[g] = pif.peak;
      tpm_peak_track u_track (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .pk      (pif)
      );
    end
  endgenerate

  // Reads answer one cycle later; writes carry no data into any register.
  always_comb begin
    rd_data_next = rd_data_reg;
    rd_ack_next  = cmd_rd;
    cmd_err_next = 1'b0;
    if (cmd_rd) begin
      if (cmd_code == TPM_CMD_TEMP) begin
        rd_data_next = temp_reg; // RQ3
      end else if (is_peak) begin
        rd_data_next = peak_val[peak_sel[2:0]];
      end else begin
        rd_data_next = 16'h0000;
        cmd_err_next = 1'b1;
      end
    end else if (cmd_wr) begin
      cmd_err_next = !(wr_ok && (is_peak || cmd_code == TPM_CMD_CLEAR)); // RQ3 RQ8
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_data_reg <= 16'h0000;
      rd_ack_reg  <= 1'b0;
      cmd_err_reg <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      rd_ack_reg  <= rd_ack_next;
      cmd_err_reg <= cmd_err_next;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_temp_die;
    (!temp_ext && die_temp_valid && !tlm_init) |=> (temp_reg == $past(die_temp_reading));
  endproperty
  a_temp_die: assert property (p_temp_die) else $error("die temperature not reported"); // RQ1

  property p_temp_ext;
    (temp_ext && external_temp_valid && !tlm_init) |=> (temp_reg == $past(external_temp_sense_pin));
  endproperty
  a_temp_ext: assert property (p_temp_ext) else $error("sense voltage not reported"); // RQ1

  property p_temp_init;
    tlm_init |=> (temp_reg == TPM_TLM_INIT);
  endproperty
  a_temp_init: assert property (p_temp_init) else $error("reading not set to init value"); // RQ10

  sequence s_rd_temp;
    cmd_rd && cmd_code == TPM_CMD_TEMP && !cmd_wr;
  endsequence
  property p_rd_temp;
    s_rd_temp |=> (rd_ack_reg && !cmd_err_reg && rd_data_reg == $past(temp_reg));
  endproperty
  a_rd_temp: assert property (p_rd_temp) else $error("temperature read wrong"); // RQ3

  property p_temp_ro;
    (cmd_wr && !cmd_rd && cmd_code == TPM_CMD_TEMP) |=> cmd_err_reg;
  endproperty
  a_temp_ro: assert property (p_temp_ro) else $error("write to read-only not flagged"); // RQ3

  sequence s_peak_wr;
    cmd_wr && !cmd_rd && is_peak && cmd_wr_bytes <= TPM_WR_MAX_BYTES;
  endsequence
  property p_peak_wr_ok;
    s_peak_wr |=> !cmd_err_reg;
  endproperty
  a_peak_wr_ok: assert property (p_peak_wr_ok) else $error("peak write flagged as error"); // RQ8

  // A clear with no conversion in the same cycle must leave every peak at the restart value.
  sequence s_clear_quiet;
    clear_all && !tlm_init && !output_voltage_valid && !input_voltage_valid && !temp_new_valid &&
      !output_current_valid && !input_current_valid;
  endsequence
  property p_clear_all;
    s_clear_quiet |=> (peak_val[TPM_PK_VOUT] == TPM_TLM_INIT) && (peak_val[TPM_PK_VIN] == TPM_TLM_INIT) &&
      (peak_val[TPM_PK_TEMP] == TPM_TLM_INIT) && (peak_val[TPM_PK_IOUT] == TPM_TLM_INIT) &&
      (peak_val[TPM_PK_IIN] == TPM_TLM_INIT);
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear-all did not reset peaks"); // RQ7

  property p_rd_ack;
    cmd_rd |=> rd_ack_reg;
  endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read not acknowledged"); // RQ3

  property p_wr_long;
    (cmd_wr && !cmd_rd && cmd_wr_bytes > TPM_WR_MAX_BYTES) |=> (cmd_err_reg && !rd_ack_reg);
  endproperty
  a_wr_long: assert property (p_wr_long) else $error("over-long write not flagged"); // RQ8

  property p_temp_peak;
    (temp_new_valid && !tlm_init && !clear_all && !(wr_ok && is_peak && peak_sel == 8'(TPM_PK_TEMP)))
      |=> ($signed(peak_val[TPM_PK_TEMP]) >= $signed(temp_reg));
  endproperty
  a_temp_peak: assert property (p_temp_peak) else $error("temperature peak below reading"); // RQ5
endmodule
`default_nettype wire

// *** src/tpm_pkg.sv ***
`default_nettype none
package tpm_pkg;
  localparam int          TPM_W          = 16;
  localparam int          TPM_NPEAK      = 5;
  localparam logic [15:0] TPM_TLM_INIT   = 16'h8000;
  localparam int          TPM_TEMP_SRC_BIT = 2;
  // Command codes seen by the register access port.
  localparam logic [7:0]  TPM_CMD_TEMP   = 8'h10;
  localparam logic [7:0]  TPM_CMD_PEAK0  = 8'h11;
  localparam logic [7:0]  TPM_CMD_CLEAR  = 8'h16;
  // Peak slots, offset from TPM_CMD_PEAK0.
  localparam int          TPM_PK_VOUT    = 0;
  localparam int          TPM_PK_VIN     = 1;
  localparam int          TPM_PK_TEMP    = 2;
  localparam int          TPM_PK_IOUT    = 3;
  localparam int          TPM_PK_IIN     = 4;
  localparam logic [1:0]  TPM_WR_MAX_BYTES = 2'h2;
  typedef logic [15:0] tpm_word_t;
endpackage
`default_nettype wire

// *** src/tpm_peak_if.sv ***
`default_nettype none
interface tpm_peak_if;
  logic [15:0] sample;
  logic        valid;
  logic        clear;
  logic [15:0] peak;
  modport track (input sample, input valid, input clear, output peak);
  modport feed  (output sample, output valid, output clear, input peak);
endinterface
`default_nettype wire

// *** src/tpm_peak_track.sv ***
`default_nettype none
module tpm_peak_track
  import tpm_pkg::*;
(
  // Clock and reset.
  input wire logic    sys_clk,
  input wire logic    sys_rst,
  // Measurement feed and peak result.
  tpm_peak_if.track   pk
);
  logic [15:0] peak_reg;
  logic [15:0] peak_next;

  // A clear restarts tracking; a sample in the same cycle becomes the first peak.
  always_comb begin
    peak_next = peak_reg;
    if (pk.clear) begin
      peak_next = pk.valid ? pk.sample : TPM_TLM_INIT; // RQ7
    end else if (pk.valid && ($signed(pk.sample) > $signed(peak_reg))) begin
      peak_next = pk.sample; // RQ11
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      peak_reg <= TPM_TLM_INIT; // RQ10
    end else begin
      peak_reg <= peak_next;
    end
  end

  assign pk.peak = peak_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_peak_rise;
    (pk.valid && !pk.clear && $signed(pk.sample) > $signed(peak_reg)) |=> (peak_reg == $past(pk.sample));
  endproperty
  a_peak_rise: assert property (p_peak_rise) else $error("peak did not take larger sample"); // RQ11

  property p_peak_keep;
    (!pk.clear && !(pk.valid && $signed(pk.sample) > $signed(peak_reg))) |=> $stable(peak_reg);
  endproperty
  a_peak_keep: assert property (p_peak_keep) else $error("peak changed without cause"); // RQ4

  property p_peak_clear;
    (pk.clear && !pk.valid) |=> (peak_reg == TPM_TLM_INIT);
  endproperty
  a_peak_clear: assert property (p_peak_clear) else $error("peak not restarted by clear"); // RQ7
endmodule
`default_nettype wire

// *** sim/tpm_host_model.sv ***
`default_nettype none
module tpm_host_model
(
  // Clock.
  input  wire logic               sys_clk,
  // Configuration and register access port.
  output var  logic [7:0]         maker_configuration,
  output var  logic [7:0]         cmd_code,
  output var  logic               cmd_rd,
  output var  logic               cmd_wr,
  output var  logic [1:0]         cmd_wr_bytes,
  // Answers.
  input  wire tpm_pkg::tpm_word_t rd_data_reg,
  input  wire logic               rd_ack_reg,
  input  wire logic               cmd_err_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  import tpm_pkg::*;
  initial begin
    maker_configuration = 8'h00;
    cmd_code = 8'h00;
    cmd_rd = 1'b0;
    cmd_wr = 1'b0;
    cmd_wr_bytes = 2'h0;
  end
  // One access; the answer is taken one cycle after the strobe.
  task access(input logic [7:0] c, input logic rd, input logic [1:0] n, output tpm_word_t d, output logic a,
              output logic e);
    @(negedge sys_clk);
    cmd_code = c;
    cmd_rd = rd;
    cmd_wr = !rd;
    cmd_wr_bytes = n;
    @(negedge sys_clk);
    cmd_rd = 1'b0;
    cmd_wr = 1'b0;
    cmd_code = ~c;
    cmd_wr_bytes = ~n;
    d = rd_data_reg;
    a = rd_ack_reg;
    e = cmd_err_reg;
  endtask
  // Switching the temperature source also restarts the temperature peak.
  task set_source(input logic ext);
    tpm_word_t d;
    logic      a;
    logic      e;
    @(negedge sys_clk);
    maker_configuration[TPM_TEMP_SRC_BIT] = ext;
    access(TPM_CMD_PEAK0 + 8'(TPM_PK_TEMP), 1'b0, 2'h0, d, a, e);
  endtask
endmodule
`default_nettype wire

// *** sim/telemetry_peak_monitor_test.sv ***
`default_nettype none
`define CHK(g, w) begin n_tests++; if ((g) !== (w)) begin errors++; $display("Error %0t: %h vs %h", $time, g, w); end end
module telemetry_peak_monitor_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tpm_pkg::*;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       run_cycle = 1'b0;
  logic       maker_soft_reset = 1'b0;
  logic [5:0] vv = 6'h00;
  tpm_word_t  cv [0:5] = '{default: 16'h0000};
  tpm_word_t  exp_pk [0:4];
  tpm_word_t  exp_temp;
  logic       ext_sel = 1'b0;
  logic [7:0] cfg, code;
  logic       crd, cwr, ack, err;
  logic [1:0] nb;
  tpm_word_t  rdat;
  tpm_word_t  last_rd = 16'h0000;
  int         errors = 0;
  int         n_tests = 0;
  int         cyc = 0;
  always #5 sys_clk = ~sys_clk;
  tpm_monitor i_tpm_monitor (.sys_clk(sys_clk), .sys_rst(sys_rst), .run_cycle(run_cycle),
    .maker_soft_reset(maker_soft_reset), .maker_configuration(cfg),
    .output_voltage_reading(cv[0]), .output_voltage_valid(vv[0]), .input_voltage_reading(cv[1]),
    .input_voltage_valid(vv[1]), .die_temp_reading(cv[2]), .die_temp_valid(vv[2]),
    .output_current_reading(cv[3]), .output_current_valid(vv[3]), .input_current_reading(cv[4]),
    .input_current_valid(vv[4]), .external_temp_sense_pin(cv[5]), .external_temp_valid(vv[5]),
    .cmd_code(code), .cmd_rd(crd), .cmd_wr(cwr), .cmd_wr_bytes(nb), .rd_data_reg(rdat),
    .rd_ack_reg(ack), .cmd_err_reg(err));
  tpm_host_model i_tpm_host_model (.sys_clk(sys_clk), .maker_configuration(cfg), .cmd_code(code),
    .cmd_rd(crd), .cmd_wr(cwr), .cmd_wr_bytes(nb), .rd_data_reg(rdat), .rd_ack_reg(ack), .cmd_err_reg(err));
  task give_verdict;
    $display("errors %0d, comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict;
    end
  end
  function automatic tpm_word_t pk_upd(input tpm_word_t p, input tpm_word_t s);
    return ($signed(s) > $signed(p)) ? s : p;
  endfunction
  task init_exp;
    exp_temp = TPM_TLM_INIT;
    foreach (exp_pk[i]) exp_pk[i] = TPM_TLM_INIT;
  endtask
  task rd(input logic [7:0] c, input tpm_word_t w, input logic we);
    tpm_word_t d;
    logic      a;
    logic      e;
    i_tpm_host_model.access(c, 1'b1, 2'h0, d, a, e);
    `CHK(e, we)
    if (!we) `CHK(a, 1'b1)
    `CHK(d, w)
    last_rd = w;
  endtask
  task wr(input logic [7:0] c, input logic [1:0] n, input logic we);
    tpm_word_t d;
    logic      a;
    logic      e;
    i_tpm_host_model.access(c, 1'b0, n, d, a, e);
    `CHK(e, we)
    `CHK(a, 1'b0)
    `CHK(d, last_rd)
  endtask
  task chk_all;
    rd(TPM_CMD_TEMP, exp_temp, 1'b0);
    for (int i = 0; i < TPM_NPEAK; i++) begin
      rd(TPM_CMD_PEAK0 + 8'(i), exp_pk[i], 1'b0);
    end
  endtask
  // Random values every cycle, each channel strobed valid at random, with extreme values mixed in.
  task conv(input int k);
    repeat (k) begin
      @(negedge sys_clk);
      for (int i = 0; i < 6; i++) begin
        cv[i] = 16'($urandom);
        vv[i] = 1'($urandom);
        if ($urandom_range(0, 7) == 0) cv[i] = ($urandom_range(0, 1) != 0) ? 16'h7FFF : 16'h8001;
      end
      @(posedge sys_clk);
      for (int i = 0; i < 5; i++) begin
        if (vv[i] && i != TPM_PK_TEMP) exp_pk[i] = pk_upd(exp_pk[i], cv[i]);
      end
      if (vv[ext_sel ? 5 : 2]) exp_temp = cv[ext_sel ? 5 : 2];
      if (vv[ext_sel ? 5 : 2]) exp_pk[TPM_PK_TEMP] = pk_upd(exp_pk[TPM_PK_TEMP], exp_temp);
    end
    @(negedge sys_clk);
    vv = 6'h00;
  endtask
  initial begin
    void'($urandom(31));
    init_exp();
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    chk_all();
    conv(200);
    chk_all();
    i_tpm_host_model.set_source(1'b1);
    ext_sel = 1'b1;
    exp_pk[TPM_PK_TEMP] = TPM_TLM_INIT;
    conv(200);
    chk_all();
    for (int i = 0; i < TPM_NPEAK; i++) begin
      conv(20);
      wr(TPM_CMD_PEAK0 + 8'(i), 2'($urandom_range(0, 2)), 1'b0);
      exp_pk[i] = TPM_TLM_INIT;
      chk_all();
    end
    conv(30);
    wr(TPM_CMD_TEMP, 2'h2, 1'b1);
    wr(TPM_CMD_PEAK0, 2'h3, 1'b1);
    rd(TPM_CMD_CLEAR, 16'h0000, 1'b1);
    chk_all();
    wr(TPM_CMD_CLEAR, 2'h2, 1'b0);
    foreach (exp_pk[i]) exp_pk[i] = TPM_TLM_INIT;
    chk_all();
    for (int k = 0; k < 3; k++) begin
      conv(20);
      if (k == 0) maker_soft_reset = 1'b1;
      else if (k == 1) run_cycle = 1'b1;
      else sys_rst = 1'b1;
      @(negedge sys_clk);
      maker_soft_reset = 1'b0;
      run_cycle = 1'b0;
      sys_rst = 1'b0;
      init_exp();
      chk_all();
    end
    give_verdict();
  end
endmodule
`default_nettype wire
